// [rtl/pms_defines.svh]
// Functional notes
// - Four ports; mode auto 11, semi 10, manual 01
// - Mode 00 shuts port down: no detect, no power
// - Manual port runs one detect cycle per command
// - Manual port obeys power on/off commands anytime; code powers on only after a good detect, else startup fault
// - Semi-auto repolls and reports, powers only on command
// - Auto powers port itself after good detect and class
// - Auto mode alone loads thresholds from class
// - Single-signature classes 1-8 map to threshold triples
// - Dual-signature classes 1-5 map to channel triples
// - Dual port power cut sums powered channel cuts
// - Any fault removes that port or channel power; code cuts only the faulted channel, also on single-signature ports
// - Enabled disconnect removes that port or channel power; code cuts only that channel, also on single-signature ports
// - Host power-off command works in every mode
// - Reset on power-up, pin low, or reset-all bit
// - Strap changes after reset are ignored
// - Strap high: auto, detect and class enabled
// - Connection check compares two first-channel readings
// - Attach or removal during check reports invalid
// - Accept 19k-26.5k, reject above 33k, below 15k
// - Status kept for port, channel A, channel B
// - Power-on commands split per channel, one slave
// - Power-on without good detect raises startup fault; code raises none while the port is in mode 00
// - Detection off when shutdown or detect disabled
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH
`define PMS_NPORT        4
`define PMS_MODE_SHDN    2'h0
`define PMS_MODE_MAN     2'h1
`define PMS_MODE_SEMI    2'h2
`define PMS_MODE_AUTO    2'h3
`define PMS_OFF_CTRL0    8'h00
`define PMS_OFF_CMD      8'h10
`define PMS_OFF_STAT0    8'h20
`define PMS_OFF_GLOB     8'h30
`define PMS_OFF_THRA0    8'h40
`define PMS_OFF_THRB0    8'h50
`define PMS_OFF_PCUT0    8'h60
`define PMS_CMD_DET      3:0
`define PMS_CMD_ON_A     7:4
`define PMS_CMD_ON_B     11:8
`define PMS_CMD_OFF      15:12
`define PMS_STAT_SFLT    21
`define PMS_GLOB_RST     0
`define PMS_RSIG_MIN     10'h0AA
`define PMS_RSIG_MAX     10'h122
`define PMS_CC_DELTA     8'h08
`define PMS_T_REPOLL_MS  100
`define PMS_CLK_MHZ      200
`endif

// [rtl/pms_pkg.sv]
`default_nettype none
package pms_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_CCHK, ST_DET, ST_CLS, ST_WAIT}
        pms_st_t;
    typedef enum logic [1:0] {K_CC, K_DET, K_CLS} pms_kind_t;
    typedef enum logic [2:0] {DR_UNK, DR_LOW, DR_GOOD, DR_HIGH, DR_CCINV,
                              DR_CHAN} pms_det_t;
    typedef enum logic [1:0] {CC_NONE, CC_SINGLE, CC_DUAL, CC_INV} pms_cc_t;
    typedef struct packed {
        logic       disc_en;
        logic       cls_en;
        logic       det_en;
        logic [1:0] mode;
    } pms_ctrl_t;
    typedef struct packed {
        logic       done;
        logic       chg;
        logic [7:0] i1;
        logic [7:0] i2;
        logic [9:0] res_a;
        logic [9:0] res_b;
        logic [3:0] cls_a;
        logic [3:0] cls_b;
    } pms_rsp_t;
    typedef struct packed {
        logic      req;
        pms_kind_t kind;
    } pms_req_t;
    typedef struct packed {
        logic [9:0]  icut;
        logic [10:0] ilim;
        logic [13:0] pcut;
    } pms_row_t;
    typedef struct packed {
        logic [9:0]  icut_a;
        logic [10:0] ilim_a;
        logic [9:0]  icut_b;
        logic [10:0] ilim_b;
        logic [13:0] pcut;
    } pms_thr_t;
endpackage
`default_nettype wire

// [rtl/pms_top.sv]
`include "pms_defines.svh"
`default_nettype none
module pms_top
    import pms_pkg::*;
#(
    parameter int unsigned NPORT      = `PMS_NPORT,
    parameter int unsigned REPOLL_CYC = `PMS_T_REPOLL_MS * 1000 * `PMS_CLK_MHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        auto_strap,
    input  wire pms_rsp_t    afe_rsp   [NPORT],
    input  wire logic [3:0]  fault_a,
    input  wire logic [3:0]  fault_b,
    input  wire logic [3:0]  disc_a,
    input  wire logic [3:0]  disc_b,
    output var  pms_req_t    meas_req  [NPORT],
    output var  logic [3:0]  pwr_en_a,
    output var  logic [3:0]  pwr_en_b,
    output var  pms_thr_t    thr       [NPORT]
);
    localparam int unsigned CW = $clog2(REPOLL_CYC + 1);

    // ==========================================================
    // Functions
    function automatic logic port_hit(input logic [7:0] a,
                                      input logic [7:0] base);
        port_hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    endfunction

    function automatic pms_det_t det_eval(input logic [9:0] r);
        if (r < `PMS_RSIG_MIN)
            det_eval = DR_LOW;
        else if (r > `PMS_RSIG_MAX)
            det_eval = DR_HIGH;
        else
            det_eval = DR_GOOD;
    endfunction

    function automatic pms_cc_t cc_eval(input pms_rsp_t r);
        logic [7:0] d;
        d = (r.i2 > r.i1) ? r.i2 - r.i1 : r.i1 - r.i2;
        if (r.chg)
            cc_eval = CC_INV;
        else if (d > `PMS_CC_DELTA)
            cc_eval = CC_SINGLE;
        else
            cc_eval = CC_DUAL;
    endfunction

    function automatic pms_row_t row_single(input logic [3:0] c);
        unique case (c)
            4'h1: row_single = '{10'h05E, 11'h1A9, 14'h021F};
            4'h2: row_single = '{10'h096, 11'h1A9, 14'h0365};
            4'h4: row_single = '{10'h27E, 11'h352, 14'h0E38};
            4'h5: row_single = '{10'h245, 11'h352, 14'h1496};
            4'h6: row_single = '{10'h2DB, 11'h352, 14'h1B58};
            4'h7: row_single = '{10'h339, 11'h427, 14'h2224};
            4'h8: row_single = '{10'h3CF, 11'h48F, 14'h25BC};
            default: row_single = '{10'h152, 11'h1A9, 14'h079E};
        endcase
    endfunction

    function automatic pms_row_t row_dual(input logic [3:0] c);
        unique case (c)
            4'h1: row_dual = '{10'h05E, 11'h1A9, 14'h021F};
            4'h2: row_dual = '{10'h096, 11'h1A9, 14'h0365};
            4'h4: row_dual = '{10'h27E, 11'h352, 14'h0E38};
            4'h5: row_dual = '{10'h3CF, 11'h48F, 14'h12DE};
            default: row_dual = '{10'h152, 11'h1A9, 14'h079E};
        endcase
    endfunction

    // ==========================================================
    // Strap capture and soft reset
    logic strap_s1_q;
    logic strap_s2_q;
    logic strap_q;
    logic init_q;
    logic soft_rst_q;
    logic wr_en;
    logic cfg_load;

    assign wr_en    = psel && penable && pwrite;
    assign cfg_load = !init_q || soft_rst_q;

    // Free-running so the strap is settled when reset lifts
    always_ff @(posedge pclk) begin
        strap_s1_q <= auto_strap;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q     <= 1'b0;
            strap_q    <= 1'b0;
            soft_rst_q <= 1'b0;
        end else begin
            init_q     <= 1'b1;
            soft_rst_q <= wr_en && (paddr == `PMS_OFF_GLOB)
                          && pwdata[`PMS_GLOB_RST];
            if (cfg_load)
                strap_q <= strap_s2_q;
        end
    end

    // ==========================================================
    // Control registers and commands
    pms_ctrl_t  ctrl_q [NPORT];
    logic       cmd_wr;
    logic [3:0] cmd_det;
    logic [3:0] cmd_on_a;
    logic [3:0] cmd_on_b;
    logic [3:0] cmd_off;

    assign cmd_wr   = wr_en && (paddr == `PMS_OFF_CMD);
    assign cmd_det  = cmd_wr ? pwdata[`PMS_CMD_DET] : 4'h0;
    assign cmd_on_a = cmd_wr ? pwdata[`PMS_CMD_ON_A] : 4'h0;
    assign cmd_on_b = cmd_wr ? pwdata[`PMS_CMD_ON_B] : 4'h0;
    assign cmd_off  = cmd_wr ? pwdata[`PMS_CMD_OFF] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++)
                ctrl_q[p] <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (cfg_load)
                    ctrl_q[p] <= strap_s2_q ?
                        '{1'b1, 1'b1, 1'b1, `PMS_MODE_AUTO} : '0;
                else if (wr_en && port_hit(paddr, `PMS_OFF_CTRL0)
                         && paddr[3:2] == 2'(p))
                    ctrl_q[p] <= pwdata[4:0];
            end
        end
    end

    // ==========================================================
    // Per-port detect sequencer
    pms_st_t    st_q      [NPORT];
    logic [1:0] act_q     [NPORT];
    logic [CW-1:0] cnt_q  [NPORT];
    pms_det_t   det_p_q   [NPORT];
    pms_det_t   det_a_q   [NPORT];
    pms_det_t   det_b_q   [NPORT];
    pms_cc_t    cc_q      [NPORT];
    logic [3:0] cls_a_q   [NPORT];
    logic [3:0] cls_b_q   [NPORT];
    logic [3:0] dcmd_q;
    logic [3:0] auto_on_q;
    logic [3:0] pwr_a_q;
    logic [3:0] pwr_b_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcmd_q    <= 4'h0;
            auto_on_q <= 4'h0;
            for (int p = 0; p < NPORT; p++) begin
                st_q[p]     <= ST_IDLE;
                act_q[p]    <= `PMS_MODE_SHDN;
                cnt_q[p]    <= '0;
                det_p_q[p]  <= DR_UNK;
                det_a_q[p]  <= DR_UNK;
                det_b_q[p]  <= DR_UNK;
                cc_q[p]     <= CC_NONE;
                cls_a_q[p]  <= 4'h0;
                cls_b_q[p]  <= 4'h0;
                meas_req[p] <= '{1'b0, K_CC};
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                meas_req[p].req <= 1'b0;
                auto_on_q[p]    <= 1'b0;
                if (cmd_det[p] && act_q[p] == `PMS_MODE_MAN)
                    dcmd_q[p] <= 1'b1;
                if (st_q[p] == ST_IDLE || st_q[p] == ST_WAIT)
                    act_q[p] <= ctrl_q[p].mode;
                if (soft_rst_q) begin
                    st_q[p]    <= ST_IDLE;
                    dcmd_q[p]  <= 1'b0;
                    det_p_q[p] <= DR_UNK;
                    det_a_q[p] <= DR_UNK;
                    det_b_q[p] <= DR_UNK;
                    cc_q[p]    <= CC_NONE;
                end else begin
                    unique case (st_q[p])
                        ST_IDLE: begin
                            if (act_q[p] != `PMS_MODE_SHDN
                                && ctrl_q[p].det_en
                                && !pwr_a_q[p] && !pwr_b_q[p]
                                && (act_q[p] != `PMS_MODE_MAN
                                    || dcmd_q[p])) begin
                                st_q[p]     <= ST_CCHK;
                                dcmd_q[p]   <= 1'b0;
                                meas_req[p] <= '{1'b1, K_CC};
                            end
                        end
                        ST_CCHK: begin
                            if (afe_rsp[p].done) begin
                                cc_q[p] <= cc_eval(afe_rsp[p]);
                                if (cc_eval(afe_rsp[p]) == CC_INV) begin
                                    det_p_q[p] <= DR_CCINV;
                                    det_a_q[p] <= DR_CCINV;
                                    det_b_q[p] <= DR_CCINV;
                                    st_q[p]    <= ST_WAIT;
                                    cnt_q[p]   <= '0;
                                end else begin
                                    st_q[p]     <= ST_DET;
                                    meas_req[p] <= '{1'b1, K_DET};
                                end
                            end
                        end
                        ST_DET: begin
                            if (afe_rsp[p].done) begin
                                det_a_q[p] <= det_eval(afe_rsp[p].res_a);
                                det_b_q[p] <= det_eval(afe_rsp[p].res_b);
                                det_p_q[p] <= (cc_q[p] == CC_SINGLE) ?
                                    det_eval(afe_rsp[p].res_a) : DR_CHAN;
                                if (ctrl_q[p].cls_en && (det_eval(
                                    afe_rsp[p].res_a) == DR_GOOD
                                    || (cc_q[p] == CC_DUAL && det_eval(
                                    afe_rsp[p].res_b) == DR_GOOD))) begin
                                    st_q[p]     <= ST_CLS;
                                    meas_req[p] <= '{1'b1, K_CLS};
                                end else begin
                                    st_q[p]  <= ST_WAIT;
                                    cnt_q[p] <= '0;
                                end
                            end
                        end
                        ST_CLS: begin
                            if (afe_rsp[p].done) begin
                                cls_a_q[p]   <= afe_rsp[p].cls_a;
                                cls_b_q[p]   <= afe_rsp[p].cls_b;
                                auto_on_q[p] <= (act_q[p] ==
                                                 `PMS_MODE_AUTO);
                                st_q[p]      <= ST_WAIT;
                                cnt_q[p]     <= '0;
                            end
                        end
                        ST_WAIT: begin
                            cnt_q[p] <= cnt_q[p] + 1'b1;
                            if (act_q[p] == `PMS_MODE_MAN
                                || act_q[p] == `PMS_MODE_SHDN
                                || cnt_q[p] == CW'(REPOLL_CYC - 1))
                                st_q[p] <= ST_IDLE;
                        end
                        default: st_q[p] <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Power control
    logic [3:0] good_a;
    logic [3:0] good_b;
    logic [3:0] on_a;
    logic [3:0] on_b;
    logic [3:0] kill_a;
    logic [3:0] kill_b;
    logic [3:0] sfault_q;
    logic [3:0] sflt_set;

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            if (cc_q[p] == CC_SINGLE) begin
                good_a[p] = (det_p_q[p] == DR_GOOD);
                good_b[p] = good_a[p];
                on_a[p]   = good_a[p] && (cmd_on_a[p] || cmd_on_b[p]
                            || auto_on_q[p]);
                on_b[p]   = on_a[p];
            end else begin
                good_a[p] = (cc_q[p] == CC_DUAL) && det_a_q[p] == DR_GOOD;
                good_b[p] = (cc_q[p] == CC_DUAL) && det_b_q[p] == DR_GOOD;
                on_a[p]   = good_a[p] && (cmd_on_a[p] || auto_on_q[p]);
                on_b[p]   = good_b[p] && (cmd_on_b[p] || auto_on_q[p]);
            end
            kill_a[p] = fault_a[p] || (ctrl_q[p].disc_en && disc_a[p])
                        || cmd_off[p] || act_q[p] == `PMS_MODE_SHDN
                        || soft_rst_q;
            kill_b[p] = fault_b[p] || (ctrl_q[p].disc_en && disc_b[p])
                        || cmd_off[p] || act_q[p] == `PMS_MODE_SHDN
                        || soft_rst_q;
            sflt_set[p] = act_q[p] != `PMS_MODE_SHDN
                          && ((cmd_on_a[p] && !good_a[p])
                              || (cmd_on_b[p] && !good_b[p]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_a_q <= 4'h0;
            pwr_b_q <= 4'h0;
        end else begin
            pwr_a_q <= ~kill_a & (pwr_a_q | on_a);
            pwr_b_q <= ~kill_b & (pwr_b_q | on_b);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sfault_q <= 4'h0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (sflt_set[p])
                    sfault_q[p] <= 1'b1;
                else if (soft_rst_q || (wr_en && paddr[3:2] == 2'(p)
                         && port_hit(paddr, `PMS_OFF_STAT0)
                         && pwdata[`PMS_STAT_SFLT]))
                    sfault_q[p] <= 1'b0;
            end
        end
    end

    assign pwr_en_a = pwr_a_q;
    assign pwr_en_b = pwr_b_q;

    // ==========================================================
    // Automatic thresholds
    pms_row_t rs_row [NPORT];
    pms_row_t ra_row [NPORT];
    pms_row_t rb_row [NPORT];

    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            rs_row[p] = row_single(cls_a_q[p]);
            ra_row[p] = row_dual(cls_a_q[p]);
            rb_row[p] = row_dual(cls_b_q[p]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++)
                thr[p] <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (act_q[p] == `PMS_MODE_AUTO) begin
                    if (cc_q[p] == CC_SINGLE) begin
                        thr[p] <= '{rs_row[p].icut,
                                    rs_row[p].ilim,
                                    rs_row[p].icut,
                                    rs_row[p].ilim,
                                    rs_row[p].pcut};
                    end else if (cc_q[p] == CC_DUAL) begin
                        thr[p] <= '{ra_row[p].icut,
                                    ra_row[p].ilim,
                                    rb_row[p].icut,
                                    rb_row[p].ilim,
                                    (pwr_a_q[p] ? ra_row[p].pcut
                                                : 14'h0000)
                                  + (pwr_b_q[p] ? rb_row[p].pcut
                                                : 14'h0000)};
                    end
                end
            end
        end
    end

    // ==========================================================
    // APB slave
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic        hit;
    logic [1:0]  ri;

    assign ri = paddr[3:2];
    assign hit = port_hit(paddr, `PMS_OFF_CTRL0)
                 || port_hit(paddr, `PMS_OFF_STAT0)
                 || port_hit(paddr, `PMS_OFF_THRA0)
                 || port_hit(paddr, `PMS_OFF_THRB0)
                 || port_hit(paddr, `PMS_OFF_PCUT0)
                 || paddr == `PMS_OFF_CMD || paddr == `PMS_OFF_GLOB;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (port_hit(paddr, `PMS_OFF_CTRL0))
            rdata_d = {27'h0, ctrl_q[ri]};
        else if (port_hit(paddr, `PMS_OFF_STAT0))
            rdata_d = {8'h00, act_q[ri], sfault_q[ri], pwr_b_q[ri],
                       pwr_a_q[ri], cls_b_q[ri], cls_a_q[ri], cc_q[ri],
                       det_b_q[ri], det_a_q[ri], det_p_q[ri]};
        else if (port_hit(paddr, `PMS_OFF_THRA0))
            rdata_d = {11'h000, thr[ri].ilim_a, thr[ri].icut_a};
        else if (port_hit(paddr, `PMS_OFF_THRB0))
            rdata_d = {11'h000, thr[ri].ilim_b, thr[ri].icut_b};
        else if (port_hit(paddr, `PMS_OFF_PCUT0))
            rdata_d = {18'h00000, thr[ri].pcut};
        else if (paddr == `PMS_OFF_GLOB)
            rdata_d = {30'h0, strap_q, 1'b0};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_q <= rdata_d;
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fault_kill: assert property (fault_a[0] |=> !pwr_a_q[0])
        else $error("Fault did not remove channel A power");
    a_disc_kill: assert property (ctrl_q[0].disc_en && disc_b[0]
        |=> !pwr_b_q[0])
        else $error("Disconnect did not remove channel B power");
    a_off_cmd: assert property (cmd_off[0] |=> !pwr_a_q[0] && !pwr_b_q[0])
        else $error("Power-off command ignored");
    a_start_fault: assert property (sflt_set[0] |=> sfault_q[0])
        else $error("Startup fault not raised");
    a_shdn_idle: assert property (act_q[0] == `PMS_MODE_SHDN
        && st_q[0] == ST_IDLE |=> st_q[0] == ST_IDLE && !meas_req[0].req)
        else $error("Shutdown port started a measurement");
    a_cc_invalid: assert property (st_q[0] == ST_CCHK
        && afe_rsp[0].done && afe_rsp[0].chg && !soft_rst_q
        |=> det_p_q[0] == DR_CCINV && st_q[0] == ST_WAIT)
        else $error("Change during check not reported invalid");
    a_strap_hold: assert property (init_q && !soft_rst_q
        |=> $stable(strap_q))
        else $error("Strap latch changed without reset");
    a_mode_bound: assert property (st_q[0] == ST_DET
        |=> $stable(act_q[0]))
        else $error("Mode changed within a detect cycle");
    a_auto_thr: assert property (auto_on_q[0] && cc_q[0] == CC_SINGLE
        && act_q[0] == `PMS_MODE_AUTO
        |=> thr[0].icut_a == rs_row[0].icut)
        else $error("Single-signature threshold not loaded");
    a_repoll: assert property (st_q[0] == ST_WAIT
        && act_q[0] == `PMS_MODE_SEMI && !soft_rst_q
        && cnt_q[0] == CW'(REPOLL_CYC - 1) |=> st_q[0] == ST_IDLE)
        else $error("Repoll wait did not end");

    c_auto_on: cover property (auto_on_q[0] ##1 pwr_a_q[0]);
    c_sfault: cover property (sflt_set[0] ##1 sfault_q[0]);
    c_dual: cover property (cc_q[0] == CC_DUAL && pwr_b_q[0]);
endmodule
`default_nettype wire

// [verif/pms_afe_model.sv]
`default_nettype none
// ==========
// Analog front end: answers each request after four cycles
module pms_afe_model
    import pms_pkg::*;
#(
    parameter int unsigned NPORT = 4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire pms_req_t   meas_req [NPORT],
    input  wire logic [9:0] res,
    input  wire logic [3:0] cls,
    output var  pms_rsp_t   afe_rsp  [NPORT]
);
    logic [2:0] cnt_q [NPORT];
    pms_rsp_t   hit;
    // Readings differ by more than the threshold: single signature
    assign hit = '{1'b1, 1'b0, 8'h10, 8'h30, res, res, cls, cls};
    always_ff @(posedge pclk or negedge presetn) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!presetn) begin
                cnt_q[p]   <= 3'h0;
                afe_rsp[p] <= '0;
            end else begin
                cnt_q[p]   <= meas_req[p].req ? 3'h4 :
                              (cnt_q[p] != 3'h0 ? cnt_q[p] - 3'h1 : 3'h0);
                afe_rsp[p] <= (cnt_q[p] == 3'h1) ? hit : ~hit;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top
    import pms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, auto_strap;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] fault_a, fault_b, disc_a, disc_b, pwr_en_a, pwr_en_b, cls;
    logic [9:0] res;
    logic e;
    pms_rsp_t afe_rsp [4];
    pms_req_t meas_req [4];
    pms_thr_t thr [4];
    int n_errors = 0;
    int cmp_count = 0;
    pms_top #(.NPORT(4), .REPOLL_CYC(16)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .auto_strap(auto_strap), .afe_rsp(afe_rsp), .fault_a(fault_a),
        .fault_b(fault_b), .disc_a(disc_a), .disc_b(disc_b),
        .meas_req(meas_req),
        .pwr_en_a(pwr_en_a), .pwr_en_b(pwr_en_b), .thr(thr));
    pms_afe_model #(.NPORT(4)) afe (.pclk(pclk), .presetn(presetn),
        .meas_req(meas_req), .res(res), .cls(cls), .afe_rsp(afe_rsp));
    // ==========
    // Bus and check tasks
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_sim();
    end
    // ==========
    // Scenarios
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; auto_strap = 1; fault_a = 0; disc_a = 0;
        res = 10'h0FA; cls = 4'h8; fault_b = 0; disc_b = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0); chk("ctrl0", q[3:0], 4'hF);
        for (int i = 0; i < 400 && pwr_en_a !== 4'hF; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk("pwr_a", pwr_en_a, 4'hF);
        chk("pwr_b", pwr_en_b, 4'hF);
        chk("thr0", {thr[0].icut_a, thr[0].ilim_a},
            {10'h3CF, 11'h48F});
        chk("pcut0", thr[0].pcut, 14'h25BC);
        auto_strap <= 1'b0;
        apb(1'b0, 8'h30, 32'h0); chk("strap", q[1], 1'b1);
        fault_a <= 4'h1;
        fault_b <= 4'h2;
        repeat (2) @(posedge pclk);
        chk("fault", pwr_en_a[0], 1'b0);
        chk("fault_b", pwr_en_b[1], 1'b0);
        fault_a <= 4'h0;
        fault_b <= 4'h0;
        apb(1'b1, 8'h04, 32'h1F);
        disc_a <= 4'h2;
        disc_b <= 4'h1;
        repeat (2) @(posedge pclk);
        chk("disc", pwr_en_a[1], 1'b0);
        chk("disc_b", pwr_en_b[0], 1'b0);
        disc_a <= 4'h0;
        disc_b <= 4'h0;
        apb(1'b1, 8'h10, 32'h4000); chk("off", pwr_en_a[2], 1'b0);
        apb(1'b0, 8'hFC, 32'h0); chk("unmapped", q, 32'h0);
        chk("slverr", e, 1'b1);
        res <= 10'h050;
        apb(1'b1, 8'h0C, 32'h0E);
        apb(1'b1, 8'h10, 32'h8000);
        repeat (80) @(posedge pclk);
        apb(1'b1, 8'h10, 32'h0080);
        apb(1'b0, 8'h2C, 32'h0);
        chk("sflt", q[21], 1'b1);
        chk("low", q[2:0], 3'h1);
        chk("on3", pwr_en_a[3], 1'b0);
        apb(1'b1, 8'h0C, 32'h0D);
        repeat (40) @(posedge pclk);
        res <= 10'h0FA;
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h2C, 32'h0); chk("man_idle", q[2:0], 3'h1);
        apb(1'b1, 8'h10, 32'h0008);
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h2C, 32'h0); chk("man_det", q[2:0], 3'h2);
        apb(1'b1, 8'h10, 32'h0080);
        chk("man_on", {pwr_en_a[3], pwr_en_b[3]}, 2'h3);
        chk("auto2", pwr_en_a[2], 1'b1);
        apb(1'b1, 8'h08, 32'h00);
        repeat (2) @(posedge pclk);
        chk("shdn", {pwr_en_a[2], pwr_en_b[2]}, 2'h0);
        apb(1'b1, 8'h30, 32'h1);
        apb(1'b0, 8'h00, 32'h0); chk("rst", q[4:0], 5'h00);
        chk("rst_pwr", {pwr_en_a, pwr_en_b}, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
